// File: smgc_top.sv
// Global control, interrupt arbitration, pin muxing and sync serial port
`timescale 1ns/100ps
`include "smgc_cfg.svh"
// Behaviour
// - Stop bit gates most module clocking
// - Stop bit stays until cleared or reset
// - Seven interrupt levels, zero disables
// - Same level: sync, then A, then B
// - Acknowledge enters arbitration on level match
// - Drive arbitration number; highest wins
// - Arbitration number resets zero, no arbitration
// - Vector is base plus interface code
// - Direction register sets each pin direction
// - Assign register selects sync port pins
// - Serial clock pin follows port enable
// - Async enables leave their pins as port I/O
// - Full duplex 8 or 16 bits, order select
// - Master makes clock at selected rate
// - Unselected slave leaves bus alone
// - Write during transfer flags collision
// - Mode fault flags and drops drivers
// - Control register accessible any time
// - Status bits set only by hardware
// - Unimplemented bits ignore writes, read zero
module smgc_top
    import smgc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [3:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    // Async port interrupt sources
    input wire logic asyncAIrqSrc,
    input wire logic asyncBIrqSrc,
    // Interrupt acknowledge on the module bus
    input wire logic iackCycle,
    input wire logic [2:0] iackLevel,
    input wire logic [3:0] arbBusIn,
    output logic [2:0] irqLevel,
    output logic [3:0] arbDrive,
    output logic arbDriveEn,
    output logic [7:0] vecOut,
    output logic vecValid,
    // Clock gate for the rest of the module
    output logic modClkEn,
    // Pins
    input wire logic [7:0] pinIn,
    output smgc_pins_t pins
);
    logic [15:0] mcr_ff;
    logic [7:0] ila_ff;
    logic [7:0] ivr_ff;
    logic [2:0] ils_ff;
    logic [7:0] pdat_ff;
    logic [7:0] par_ff;
    logic [7:0] ddr_ff;
    logic [7:0] scr_ff;
    logic [1:0] acta_ff;
    logic [1:0] actb_ff;
    logic spif_ff;
    logic wcol_ff;
    logic modf_ff;
    logic [15:0] shift_ff;
    logic [15:0] rbuf_ff;
    logic [4:0] bitCnt_ff;
    logic [7:0] baud_ff;
    logic [7:0] divCnt_ff;
    logic sck_ff;
    logic [7:0] pinS1_ff;
    logic [7:0] pinS2_ff;
    logic sckPrev_ff;
    logic statusRead_ff;
    smgc_state_t st_ff;
    logic [15:0] rdata_ff;
    logic [2:0] irq_ff;
    logic [3:0] arb_ff;
    logic arbEn_ff;
    logic [7:0] vec_ff;
    logic vecV_ff;
    logic modClk_ff;
    smgc_pins_t pins_ff;

    // Simultaneous full-duplex shift bit index
    function automatic logic [3:0] bitIdx(input logic [4:0] n,
            input logic sixteen, input logic lsbf);
        logic [4:0] top;
        top = sixteen ? `SMGC_BITS16 : `SMGC_BITS8;
        bitIdx = lsbf ? n[3:0] : 4'(top - 5'h01 - n);
    endfunction

    wire stopOn = mcr_ff[`SMGC_MCR_STOP];
    wire sync_port_enable = scr_ff[`SMGC_SCR_SPE];
    wire mstr = scr_ff[`SMGC_SCR_MSTR];
    wire sixteen = scr_ff[`SMGC_SCR_SIZE];
    wire lsbf = scr_ff[`SMGC_SCR_LSBF];
    wire wrSel = regWr && !stopOn;
    wire [4:0] nBits = sixteen ? `SMGC_BITS16 : `SMGC_BITS8;
    wire ssLow = !pinS2_ff[`SMGC_PIN_SS];
    wire ssAssigned = par_ff[`SMGC_PIN_SS];
    wire slaveSel = sync_port_enable && !mstr && ssAssigned && ssLow;
    wire modeFault = sync_port_enable && mstr && ssAssigned && ssLow;
    wire busy = st_ff == SMGC_SHIFT;
    wire sdrWr = wrSel && regAddr == `SMGC_A_SDR;
    wire sdrRd = regRd && regAddr == `SMGC_A_SDR;
    wire tick = divCnt_ff == baud_ff;
    wire sckIn = pinS2_ff[`SMGC_PIN_SCK];
    wire sckRise = sckIn && !sckPrev_ff;
    wire sckFall = !sckIn && sckPrev_ff;
    wire doneEv = busy && bitCnt_ff == nBits;
    wire misoBit = pinS2_ff[`SMGC_PIN_MISO];
    wire mosiBit = pinS2_ff[`SMGC_PIN_MOSI];
    wire [3:0] curIdx = bitIdx(bitCnt_ff, sixteen, lsbf);
    wire outBit = shift_ff[curIdx];

    // per interface request, zero level disables
    // request held while enabled flag stays
    wire spReq = spif_ff && scr_ff[`SMGC_SCR_SPIE] && ils_ff != 3'h0;
    wire aReq = asyncAIrqSrc && ila_ff[2:0] != 3'h0;
    wire bReq = asyncBIrqSrc && ila_ff[6:4] != 3'h0;
    wire [2:0] lvS = spReq ? ils_ff : 3'h0;
    wire [2:0] lvA = aReq ? ila_ff[2:0] : 3'h0;
    wire [2:0] lvB = bReq ? ila_ff[6:4] : 3'h0;
    wire pickS = lvS != 3'h0 && lvS >= lvA && lvS >= lvB;
    wire pickA = !pickS && lvA != 3'h0 && lvA >= lvB;
    wire [2:0] winLv = pickS ? lvS : (pickA ? lvA : lvB);
    wire [1:0] winSrc = pickS ? `SMGC_VEC_S :
        (pickA ? `SMGC_VEC_A : `SMGC_VEC_B);
    wire arbIn = iackCycle && winLv != 3'h0 && iackLevel == winLv &&
        mcr_ff[3:0] != 4'h0;
    // win when highest number on bus
    wire arbWin = arbIn && mcr_ff[3:0] >= arbBusIn;

    // implemented bits only, others read zero
    wire [15:0] rdMux =
        regAddr == `SMGC_A_MCR ? (mcr_ff & `SMGC_MCR_MASK) :
        regAddr == `SMGC_A_ILA ? {8'h00, ila_ff & `SMGC_ILA_MASK} :
        regAddr == `SMGC_A_IVR ? {8'h00, ivr_ff} :
        regAddr == `SMGC_A_ILS ? {13'h0000, ils_ff} :
        regAddr == `SMGC_A_PDAT ? {8'h00, pdat_ff} :
        regAddr == `SMGC_A_PPIN ? {8'h00, pinS2_ff} :
        regAddr == `SMGC_A_PAR ? {8'h00, par_ff & `SMGC_PAR_MASK} :
        regAddr == `SMGC_A_DDR ? {8'h00, ddr_ff} :
        regAddr == `SMGC_A_SCR ? {baud_ff, scr_ff & `SMGC_SCR_MASK} :
        regAddr == `SMGC_A_SSR ? {8'h00, spif_ff, wcol_ff, 1'b0,
            modf_ff, 4'h0} :
        regAddr == `SMGC_A_SDR ? rbuf_ff :
        regAddr == `SMGC_A_ACTA ? {14'h0000, acta_ff} :
        regAddr == `SMGC_A_ACTB ? {14'h0000, actb_ff} : 16'h0000;

    wire [7:0] serFunc = {acta_ff[`SMGC_ACT_TE],
        acta_ff[`SMGC_ACT_RE], actb_ff[`SMGC_ACT_TE],
        actb_ff[`SMGC_ACT_RE], par_ff[`SMGC_PIN_SS], sync_port_enable,
        par_ff[`SMGC_PIN_MOSI], par_ff[`SMGC_PIN_MISO]};
    // slave drives only data out when selected
    wire serDrvMosi = sync_port_enable && mstr && !modf_ff;
    wire serDrvMiso = slaveSel && !modf_ff;
    wire [7:0] serOut = {pdat_ff[7:4], 1'b1, sck_ff, outBit, outBit};
    wire [7:0] serOk = {4'hF, 1'b0, serDrvMosi, serDrvMosi, serDrvMiso};
    wire [7:0] nxt_oe = ddr_ff & (~serFunc | serOk);
    wire [7:0] nxt_out = (serFunc & serOut) | (~serFunc & pdat_ff);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mcr_ff <= 16'h0000;
        end else if (regWr && regAddr == `SMGC_A_MCR) begin
            // stop persists until software clears it
            mcr_ff <= regWdata & `SMGC_MCR_MASK;
        end
    end

    // register writes other than global frozen when stopped
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ila_ff <= 8'h00;
            ivr_ff <= `SMGC_IVR_RST;
            ils_ff <= 3'h0;
            pdat_ff <= 8'h00;
            par_ff <= 8'h00;
            ddr_ff <= 8'h00;
            scr_ff <= 8'h00;
            baud_ff <= `SMGC_BAUD_RST;
            acta_ff <= 2'h0;
            actb_ff <= 2'h0;
        end else if (wrSel) begin
            case (regAddr)
                `SMGC_A_ILA: ila_ff <= regWdata[7:0] & `SMGC_ILA_MASK;
                `SMGC_A_IVR: ivr_ff <= regWdata[7:0];
                `SMGC_A_ILS: ils_ff <= regWdata[2:0];
                `SMGC_A_PDAT: pdat_ff <= regWdata[7:0];
                `SMGC_A_PAR: par_ff <= regWdata[7:0] & `SMGC_PAR_MASK;
                `SMGC_A_DDR: ddr_ff <= regWdata[7:0];
                `SMGC_A_SCR: begin
                    scr_ff <= regWdata[7:0] & `SMGC_SCR_MASK;
                    baud_ff <= (regWdata[15:8] < `SMGC_BAUD_MIN) ?
                        `SMGC_BAUD_MIN : regWdata[15:8];
                end
                `SMGC_A_ACTA: acta_ff <= regWdata[1:0];
                `SMGC_A_ACTB: actb_ff <= regWdata[1:0];
                default: ila_ff <= ila_ff;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pinS1_ff <= 8'hFF;
            pinS2_ff <= 8'hFF;
            sckPrev_ff <= 1'b1;
        end else begin
            pinS1_ff <= pinIn;
            pinS2_ff <= pinS1_ff;
            sckPrev_ff <= sckIn;
        end
    end

    // baud divider, half bit per tick
    always_ff @(posedge sys_clk) begin
        if (rst || !busy || !mstr || tick) begin
            divCnt_ff <= 8'h00;
        end else if (!stopOn) begin
            divCnt_ff <= divCnt_ff + 8'h01;
        end
    end

    // transfer engine, shift out and in together
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_ff <= SMGC_IDLE;
            shift_ff <= 16'h0000;
            rbuf_ff <= 16'h0000;
            bitCnt_ff <= 5'h00;
            sck_ff <= 1'b0;
        end else if (!stopOn) begin
            case (st_ff)
                SMGC_IDLE: begin
                    sck_ff <= 1'b0;
                    bitCnt_ff <= 5'h00;
                    if (sdrWr) begin
                        shift_ff <= regWdata;
                        st_ff <= (sync_port_enable && (mstr ? !modf_ff : 1'b1)) ?
                            SMGC_SHIFT : SMGC_IDLE;
                    end
                end
                SMGC_SHIFT: begin
                    if (!sync_port_enable || modeFault) begin
                        st_ff <= SMGC_IDLE;
                    end else if (doneEv) begin
                        rbuf_ff <= shift_ff;
                        st_ff <= SMGC_DONE;
                    end else if (mstr ? (tick && !sck_ff) :
                            (slaveSel && sckRise)) begin
                        sck_ff <= mstr;
                        shift_ff[curIdx] <= mstr ? misoBit : mosiBit;
                    end else if (mstr ? (tick && sck_ff) :
                            (slaveSel && sckFall)) begin
                        sck_ff <= 1'b0;
                        bitCnt_ff <= bitCnt_ff + 5'h01;
                    end
                end
                SMGC_DONE: st_ff <= SMGC_IDLE;
                default: st_ff <= SMGC_IDLE;
            endcase
        end
    end

    // hardware sets flags; read then access clears
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            spif_ff <= 1'b0;
            wcol_ff <= 1'b0;
            modf_ff <= 1'b0;
            statusRead_ff <= 1'b0;
        end else begin
            if (regRd && regAddr == `SMGC_A_SSR) begin
                statusRead_ff <= 1'b1;
            end else if (sdrRd || sdrWr) begin
                statusRead_ff <= 1'b0;
            end
            spif_ff <= (st_ff == SMGC_DONE) ||
                (spif_ff && !(statusRead_ff && (sdrRd || sdrWr)));
            wcol_ff <= (sdrWr && busy) ||
                (wcol_ff && !(statusRead_ff && (sdrRd || sdrWr)));
            modf_ff <= modeFault || (modf_ff && !(statusRead_ff &&
                wrSel && regAddr == `SMGC_A_SCR));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= 16'h0000;
            irq_ff <= 3'h0;
            arb_ff <= 4'h0;
            arbEn_ff <= 1'b0;
            vec_ff <= 8'h00;
            vecV_ff <= 1'b0;
            modClk_ff <= 1'b1;
            pins_ff <= '0;
        end else begin
            rdata_ff <= regRd ? rdMux : 16'h0000;
            irq_ff <= winLv;
            arb_ff <= arbIn ? mcr_ff[3:0] : 4'h0;
            arbEn_ff <= arbIn;
            // vector from base and interface code
            vec_ff <= arbWin ? {ivr_ff[7:2], winSrc} : 8'h00;
            vecV_ff <= arbWin;
            modClk_ff <= !stopOn;
            pins_ff.pinOut <= nxt_out;
            pins_ff.pinOe <= nxt_oe;
        end
    end

    assign regRdata = rdata_ff;
    assign irqLevel = irq_ff;
    assign arbDrive = arb_ff;
    assign arbDriveEn = arbEn_ff;
    assign vecOut = vec_ff;
    assign vecValid = vecV_ff;
    assign modClkEn = modClk_ff;
    assign pins = pins_ff;

    noarb_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        mcr_ff[3:0] == 4'h0 |=> !arbDriveEn)
        else $error("arbitration with zero number");
    vec_form_a: assert property (@(posedge sys_clk) disable iff (rst)
        vecValid |-> vecOut[7:2] == $past(ivr_ff[7:2]))
        else $error("vector base wrong");
    ack_match_a: assert property (@(posedge sys_clk) disable iff (rst)
        arbDriveEn |-> $past(iackLevel) == $past(winLv))
        else $error("arbitration without level match");
    prio_order_a: assert property (@(posedge sys_clk) disable iff (rst)
        (spReq && aReq && ils_ff == ila_ff[2:0]) |-> winSrc == `SMGC_VEC_S)
        else $error("priority order wrong");
    lvl_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
        (ils_ff == 3'h0 && ila_ff == 8'h00) |=> irqLevel == 3'h0)
        else $error("request at level zero");
    stop_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
        (stopOn && !(regWr && regAddr == `SMGC_A_MCR)) |=> stopOn)
        else $error("stop bit dropped");
    stop_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
        stopOn |=> !modClkEn)
        else $error("clock not gated");
    wcol_set_a: assert property (@(posedge sys_clk) disable iff (rst)
        (sdrWr && busy) |=> wcol_ff)
        else $error("collision missed");
    modf_drv_a: assert property (@(posedge sys_clk) disable iff (rst)
        modf_ff |=> !pins.pinOe[`SMGC_PIN_MOSI] || !serFunc[1])
        else $error("drivers on after fault");
    slave_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        (sync_port_enable && !mstr && !slaveSel && par_ff[0]) |=> !pins.pinOe[0])
        else $error("unselected slave drives");
endmodule

// File: smgc_cfg.svh
// Register map, field positions and reset values of the serial module control
`ifndef SMGC_CFG_SVH
`define SMGC_CFG_SVH
`define SMGC_A_MCR 4'h0
`define SMGC_A_TEST 4'h1
`define SMGC_A_ILA 4'h2
`define SMGC_A_IVR 4'h3
`define SMGC_A_ILS 4'h4
`define SMGC_A_PDAT 4'h5
`define SMGC_A_PPIN 4'h6
`define SMGC_A_PAR 4'h7
`define SMGC_A_DDR 4'h8
`define SMGC_A_SCR 4'h9
`define SMGC_A_SSR 4'hA
`define SMGC_A_SDR 4'hB
`define SMGC_A_ACTA 4'hC
`define SMGC_A_ACTB 4'hD
`define SMGC_A_SRC 4'hE
`define SMGC_MCR_STOP 15
`define SMGC_MCR_PRIV 7
`define SMGC_IVR_RST 8'h0F
`define SMGC_VEC_A 2'h0
`define SMGC_VEC_B 2'h1
`define SMGC_VEC_S 2'h2
`define SMGC_SCR_SPE 6
`define SMGC_SCR_MSTR 5
`define SMGC_SCR_SIZE 4
`define SMGC_SCR_LSBF 3
`define SMGC_SCR_SPIE 2
`define SMGC_SSR_SPIF 7
`define SMGC_SSR_WCOL 6
`define SMGC_SSR_MODF 4
`define SMGC_ACT_RE 1
`define SMGC_ACT_TE 0
`define SMGC_PIN_TXA 7
`define SMGC_PIN_RXA 6
`define SMGC_PIN_TXB 5
`define SMGC_PIN_RXB 4
`define SMGC_PIN_SS 3
`define SMGC_PIN_SCK 2
`define SMGC_PIN_MOSI 1
`define SMGC_PIN_MISO 0
`define SMGC_BITS8 5'h08
`define SMGC_BITS16 5'h10
`define SMGC_MCR_MASK 16'h808F
`define SMGC_ILA_MASK 8'h77
`define SMGC_PAR_MASK 8'h0B
`define SMGC_SCR_MASK 8'h7C
`define SMGC_BAUD_RST 8'h04
`define SMGC_BAUD_MIN 8'h02
`endif

// File: smgc_pkg.sv
// Types shared by the serial module control block
package smgc_pkg;
    typedef struct packed {
        logic [7:0] pinOut;
        logic [7:0] pinOe;
    } smgc_pins_t;
    typedef struct packed {
        logic [2:0] level;
        logic [1:0] src;
        logic valid;
    } smgc_req_t;
    typedef enum logic [1:0] {
        SMGC_IDLE = 2'b00,
        SMGC_SHIFT = 2'b01,
        SMGC_DONE = 2'b10
    } smgc_state_t;
endpackage

// File: smgc_bus_model.sv
// Module bus model: runs acknowledge cycles against the block
`timescale 1ns/100ps
module smgc_bus_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Request from the bench
    input wire logic go,
    input wire logic [2:0] lvl,
    input wire logic [3:0] rival,
    input wire logic [3:0] hold,
    // Block answers
    input wire logic arbDriveEn,
    input wire logic [3:0] arbDrive,
    input wire logic vecValid,
    input wire logic [7:0] vecOut,
    // Bus lines and results
    output logic iackCycle,
    output logic [2:0] iackLevel,
    output logic [3:0] arbBusIn,
    output logic done,
    output logic gotArb,
    output logic gotValid,
    output logic [7:0] gotVec,
    output logic [3:0] gotNum
);
    logic [3:0] cnt;
    always_ff @(posedge sys_clk) begin
        done <= !rst && iackCycle && cnt == 4'h0;
        if (rst) begin
            iackCycle <= 1'b0;
            iackLevel <= 3'h0;
            arbBusIn <= 4'h0;
            cnt <= 4'h0;
        end else if (go && !iackCycle) begin
            iackCycle <= 1'b1;
            iackLevel <= lvl;
            arbBusIn <= rival;
            cnt <= hold;
            gotArb <= 1'b0;
            gotValid <= 1'b0;
        end else if (iackCycle) begin
            if (arbDriveEn) begin
                gotArb <= 1'b1;
                gotNum <= arbDrive;
            end
            if (vecValid) begin
                gotValid <= 1'b1;
                gotVec <= vecOut;
            end
            if (cnt == 4'h0) begin
                // Released lines show the inverse of their last value
                iackCycle <= 1'b0;
                iackLevel <= ~iackLevel;
                arbBusIn <= ~arbBusIn;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

// File: smgc_top_tb.sv
// Self-checking bench for the serial module control block
`timescale 1ns/100ps
`include "smgc_cfg.svh"
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin miscompares++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module smgc_top_tb;
    import smgc_pkg::*;
    logic sys_clk, rst, regWr, regRd, asyncAIrqSrc, asyncBIrqSrc;
    logic [3:0] regAddr;
    logic [15:0] regWdata, regRdata, rv;
    logic iackCycle, arbDriveEn, vecValid, modClkEn, go, done;
    logic gotArb, gotValid, sclkPrev, firstBit, clrMon;
    logic [2:0] iackLevel, irqLevel, lvl;
    logic [3:0] arbBusIn, arbDrive, rival, hold, gotNum;
    logic [7:0] vecOut, gotVec, extDrv, pinWire;
    smgc_pins_t pins;
    int miscompares, numChecks, cycles, edges, lastRise, period;
    wire mosiLvl = pins.pinOe[1] ? pins.pinOut[1] : extDrv[1];
    // MISO is looped back from the MOSI wire
    assign pinWire = {(pins.pinOe[7:1] & pins.pinOut[7:1])
        | (~pins.pinOe[7:1] & extDrv[7:1]),
        pins.pinOe[0] ? pins.pinOut[0] : mosiLvl};
    smgc_top smgc_top_inst (.sys_clk(sys_clk), .rst(rst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .asyncAIrqSrc(asyncAIrqSrc),
        .asyncBIrqSrc(asyncBIrqSrc), .iackCycle(iackCycle),
        .iackLevel(iackLevel), .arbBusIn(arbBusIn), .irqLevel(irqLevel),
        .arbDrive(arbDrive), .arbDriveEn(arbDriveEn), .vecOut(vecOut),
        .vecValid(vecValid), .modClkEn(modClkEn), .pinIn(pinWire),
        .pins(pins));
    smgc_bus_model smgc_bus_model_inst (.sys_clk(sys_clk), .rst(rst),
        .go(go), .lvl(lvl), .rival(rival), .hold(hold),
        .arbDriveEn(arbDriveEn), .arbDrive(arbDrive), .vecValid(vecValid),
        .vecOut(vecOut), .iackCycle(iackCycle), .iackLevel(iackLevel),
        .arbBusIn(arbBusIn), .done(done), .gotArb(gotArb),
        .gotValid(gotValid), .gotVec(gotVec), .gotNum(gotNum));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    // Serial clock monitor: edge count, first bit, period
    always @(posedge sys_clk) begin
        sclkPrev <= pins.pinOut[2];
        if (clrMon) edges <= 0;
        else if (pins.pinOut[2] && !sclkPrev) begin
            edges <= edges + 1;
            if (edges == 0) firstBit <= pins.pinOut[1];
            if (edges == 1) period <= cycles - lastRise;
            lastRise <= cycles;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic rdChk(input logic [3:0] a, input logic [15:0] e);
        rd(a, rv);
        `CHK(rv, e)
    endtask
    task automatic iack(input logic [2:0] l, input logic [3:0] r,
        input logic [3:0] h, input logic eArb, input logic eVal,
        input logic [7:0] eVec);
        int i;
        @(posedge sys_clk);
        lvl <= l;
        rival <= r;
        hold <= h;
        go <= 1'b1;
        @(posedge sys_clk);
        go <= 1'b0;
        for (i = 0; i < 40 && done !== 1'b1; i++) @(posedge sys_clk);
        `CHK(gotArb, eArb)
        `CHK(gotValid, eVal)
        if (eVal) `CHK(gotVec, eVec)
        if (eArb) `CHK(gotNum, 4'h5)
    endtask
    task automatic waitDone();
        int i;
        rv = 16'h0000;
        for (i = 0; i < 100 && rv[`SMGC_SSR_SPIF] !== 1'b1; i++)
            rd(`SMGC_A_SSR, rv);
    endtask
    task automatic endTest(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        {rst, regWr, regRd, asyncAIrqSrc, asyncBIrqSrc, go} = 6'h20;
        {regAddr, regWdata, lvl, rival, hold} = 31'h0;
        extDrv = 8'h3C;
        clrMon = 1'b1;
        cyc(6);
        rst <= 1'b0;
        rdChk(`SMGC_A_MCR, 16'h0000);
        rdChk(`SMGC_A_IVR, 16'h000F);
        rdChk(`SMGC_A_TEST, 16'h0000);
        rdChk(`SMGC_A_SRC, 16'h0000);
        wr(`SMGC_A_SSR, 16'hFFFF);
        rdChk(`SMGC_A_SSR, 16'h0000);
        endTest("reset");
        wr(`SMGC_A_DDR, 16'h00FF);
        wr(`SMGC_A_PDAT, 16'h00A5);
        cyc(2);
        `CHK(pins.pinOe, 8'hFF)
        `CHK(pins.pinOut, 8'hA5)
        wr(`SMGC_A_DDR, 16'h0000);
        cyc(3);
        rdChk(`SMGC_A_PPIN, 16'h003C);
        wr(`SMGC_A_ACTA, 16'h0003);
        rdChk(`SMGC_A_ACTA, 16'h0003);
        endTest("gpio");
        wr(`SMGC_A_MCR, 16'h0005);
        wr(`SMGC_A_IVR, 16'h0040);
        wr(`SMGC_A_ILA, 16'h0033);
        asyncAIrqSrc <= 1'b1;
        asyncBIrqSrc <= 1'b1;
        cyc(3);
        `CHK(irqLevel, 3'h3)
        iack(3'h3, 4'h4, 4'h2, 1'b1, 1'b1, 8'h40);
        iack(3'h2, 4'h1, 4'h2, 1'b0, 1'b0, 8'h00);
        iack(3'h3, 4'h7, 4'h6, 1'b1, 1'b0, 8'h00);
        asyncAIrqSrc <= 1'b0;
        cyc(3);
        iack(3'h3, 4'h1, 4'h6, 1'b1, 1'b1, 8'h41);
        wr(`SMGC_A_ILA, 16'h0003);
        cyc(3);
        `CHK(irqLevel, 3'h0)
        wr(`SMGC_A_ILA, 16'h0030);
        wr(`SMGC_A_MCR, 16'h0000);
        cyc(3);
        iack(3'h3, 4'h0, 4'h2, 1'b0, 1'b0, 8'h00);
        asyncBIrqSrc <= 1'b0;
        endTest("irq");
        wr(`SMGC_A_PAR, 16'h0003);
        wr(`SMGC_A_DDR, 16'h0006);
        wr(`SMGC_A_ILS, 16'h0004);
        wr(`SMGC_A_MCR, 16'h0005);
        wr(`SMGC_A_SCR, 16'h0464);
        cyc(2);
        `CHK(pins.pinOut[2], 1'b0)
        `CHK(pins.pinOe[2:1], 2'h3)
        clrMon <= 1'b0;
        wr(`SMGC_A_SDR, 16'h0080);
        waitDone();
        `CHK(edges, 8)
        `CHK(period, 10)
        `CHK(firstBit, 1'b1)
        `CHK(irqLevel, 3'h4)
        wr(`SMGC_A_ILA, 16'h0044);
        asyncAIrqSrc <= 1'b1;
        asyncBIrqSrc <= 1'b1;
        cyc(3);
        iack(3'h4, 4'h2, 4'h3, 1'b1, 1'b1, 8'h42);
        asyncAIrqSrc <= 1'b0;
        asyncBIrqSrc <= 1'b0;
        rdChk(`SMGC_A_SDR, 16'h0080);
        cyc(2);
        `CHK(irqLevel, 3'h0)
        clrMon <= 1'b1;
        wr(`SMGC_A_SCR, 16'h047C);
        clrMon <= 1'b0;
        wr(`SMGC_A_SDR, 16'h0001);
        rdChk(`SMGC_A_SCR, 16'h047C);
        wr(`SMGC_A_SDR, 16'h5555);
        waitDone();
        `CHK(rv & 16'h00D0, 16'h00C0)
        `CHK(edges, 16)
        `CHK(firstBit, 1'b1)
        rdChk(`SMGC_A_SDR, 16'h0001);
        endTest("sync port");
        wr(`SMGC_A_PAR, 16'h000B);
        extDrv <= 8'h34;
        cyc(4);
        rdChk(`SMGC_A_SSR, 16'h0010);
        `CHK(pins.pinOe[2:1], 2'h0)
        wr(`SMGC_A_SCR, 16'h0044);
        extDrv <= 8'h3C;
        wr(`SMGC_A_DDR, 16'h0001);
        cyc(4);
        `CHK(pins.pinOe[0], 1'b0)
        rdChk(`SMGC_A_SSR, 16'h0010);
        wr(`SMGC_A_SCR, 16'h0044);
        extDrv <= 8'h34;
        cyc(4);
        `CHK(pins.pinOe[0], 1'b1)
        extDrv <= 8'h3C;
        cyc(4);
        `CHK(pins.pinOe[0], 1'b0)
        endTest("faults");
        wr(`SMGC_A_SCR, 16'h0000);
        wr(`SMGC_A_ACTA, 16'h0000);
        wr(`SMGC_A_ACTB, 16'h0000);
        wr(`SMGC_A_MCR, 16'hFFFF);
        cyc(2);
        `CHK(modClkEn, 1'b0)
        rdChk(`SMGC_A_MCR, 16'h808F);
        wr(`SMGC_A_ILS, 16'h0007);
        cyc(4);
        rdChk(`SMGC_A_MCR, 16'h808F);
        rdChk(`SMGC_A_ILS, 16'h0004);
        wr(`SMGC_A_MCR, 16'h0000);
        cyc(2);
        `CHK(modClkEn, 1'b1)
        endTest("stop");
        report_and_stop();
    end
endmodule
